//--- core/comparator_ctrl_pkg.sv
// constants for the comparator control and status block
package comparator_ctrl_pkg;

  // ----------------------------------------------------------------
  // register indexes and byte addresses (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] CS_IDX   = 8'h2c;
  localparam logic [7:0] C0_IDX   = 8'h2d;
  localparam logic [7:0] C1_IDX   = 8'h2e;
  localparam logic [7:0] C2_IDX   = 8'h2f;
  localparam logic [7:0] CS_ADDR  = {CS_IDX[5:0], 2'b00};
  localparam logic [7:0] C0_ADDR  = {C0_IDX[5:0], 2'b00};
  localparam logic [7:0] C1_ADDR  = {C1_IDX[5:0], 2'b00};
  localparam logic [7:0] C2_ADDR  = {C2_IDX[5:0], 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CS_ON_BIT     = 7;
  localparam int CS_HYSTERESIS_SELECT_BIT   = 6;
  localparam int CS_FLAG_BIT   = 5;
  localparam int CS_IRQEN_BIT  = 4;
  localparam int CS_RESULT_BIT = 3;
  localparam int CS_PINEN_BIT  = 2;
  localparam int C0_PSEL_LSB   = 4;
  localparam int C0_NSEL_LSB   = 0;
  localparam int C2_PIN_W      = 3;

  // ----------------------------------------------------------------
  // reset values, encodings, analog figures
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [1:0] MODE_FALL0 = 2'b00;
  localparam logic [1:0] MODE_RISE  = 2'b01;
  localparam logic [1:0] MODE_FALL2 = 2'b10;
  localparam logic [1:0] MODE_BOTH  = 2'b11;
  localparam logic [1:0] SEL_REF0   = 2'b00;
  localparam logic [1:0] SEL_REF1   = 2'b01;
  localparam logic [1:0] SEL_DAC    = 2'b11;
  localparam int HYSTERESIS_SELECT_LOW_MV  = 20;
  localparam int HYSTERESIS_SELECT_HIGH_MV = 30;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {SEL_CS, SEL_C0, SEL_C1, SEL_C2, SEL_NONE} reg_sel_t;

endpackage : comparator_ctrl_pkg

//--- core/comparator_ctrl_regs.sv
// comparator control/status registers behind an AXI4-Lite slave
//
// Summary of operation
// - enable bit 7 of control/status turns the comparator on; 0 keeps it off
// - bit 6 selects hysteresis: 0 is 20 mV, 1 is 30 mV
// - hardware sets edge flag bit 5 on a qualifying result edge
// - flag rises bus clocks after the raw output changes, via synchroniser
// - writing 0 clears the flag; writing 1 leaves it unchanged
// - bit 4 gates the flag onto the interrupt request
// - bit 3 reads the present synchronised comparator result
// - result resets to 0 and reads 0 while disabled
// - bit 2 lets the result reach the output pin; 0 blocks it
// - edge sense: 00/10 falling, 01 rising, 11 both edges
// - input select bits 5-4 pick the positive input: ref0, ref1, DAC
// - input select low bits pick the negative input: ref0, ref1, DAC
// - input select bits 7-6 and 3-2 read 0 and ignore writes
// - in stop3, a qualifying edge gives an asynchronous wake interrupt
// - reset restores defaults, comparator and DAC both disabled
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module comparator_ctrl_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              rawCompareOutput,
  output logic                   comparatorOn,
  output logic                   hysteresisSelect,
  output logic [1:0]             plusInputSelect,
  output logic [1:0]             minusInputSelect,
  output logic [7:0]             dacLevelCtrl,
  output logic [2:0]             pinInputEnable,
  output logic                   edgeIrq,
  output logic                   resultPin,
  output logic                   resultPinOe,
  output logic                   wakeArm,
  output logic [1:0]             wakeEdgeSense
);
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must reach the register addresses");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              on;
    logic              hysteresis_select;
    logic              flag;
    logic              irqEn;
    logic              pinEn;
    logic [1:0]        mode;
    logic [1:0]        psel;
    logic [1:0]        nsel;
    logic [7:0]        dac;
    logic [2:0]        pinIn;
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0]        wData;
    logic              wLane0;
    logic              awReady;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic              irq;
    logic              pinOut;
    logic              pinOe;
    logic              wake;
  } regs_state_t;

  regs_state_t st_reg;
  regs_state_t st_next;

  result_path_if path ();

  // ----------------------------------------------------------------
  // address decode, shared by read and write
  // ----------------------------------------------------------------
  function automatic comparator_ctrl_pkg::reg_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    if ((addr >> 8) != '0) begin
      return comparator_ctrl_pkg::SEL_NONE;
    end
    case (word)
      comparator_ctrl_pkg::CS_ADDR: return comparator_ctrl_pkg::SEL_CS;
      comparator_ctrl_pkg::C0_ADDR: return comparator_ctrl_pkg::SEL_C0;
      comparator_ctrl_pkg::C1_ADDR: return comparator_ctrl_pkg::SEL_C1;
      comparator_ctrl_pkg::C2_ADDR: return comparator_ctrl_pkg::SEL_C2;
      default:                      return comparator_ctrl_pkg::SEL_NONE;
    endcase
  endfunction : decodeSel

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  assign path.compOn          = st_reg.on;
  assign path.edgeSenseSelect = st_reg.mode;

  result_sync u_sync (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .rawCompareOutput (rawCompareOutput),
    .path             (path)
  );

  edge_qualify u_qual (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .path     (path)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  comparator_ctrl_pkg::reg_sel_t wrSel;
  comparator_ctrl_pkg::reg_sel_t rdSel;
  logic                          doWrite;
  logic                          csWrite;
  logic [7:0]                    rdValue;

  assign wrSel   = decodeSel(st_reg.awAddr);
  assign rdSel   = decodeSel(araddr);
  assign doWrite = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
  assign csWrite = doWrite && st_reg.wLane0 && (wrSel == comparator_ctrl_pkg::SEL_CS);

  always_comb begin
    case (rdSel)
      comparator_ctrl_pkg::SEL_CS: rdValue = {st_reg.on, st_reg.hysteresis_select, st_reg.flag, st_reg.irqEn,
                                              path.resultNow, st_reg.pinEn, st_reg.mode};
      comparator_ctrl_pkg::SEL_C0: rdValue = {2'b00, st_reg.psel, 2'b00, st_reg.nsel};
      comparator_ctrl_pkg::SEL_C1: rdValue = st_reg.dac;
      comparator_ctrl_pkg::SEL_C2: rdValue = {5'b0_0000, st_reg.pinIn};
      default:                     rdValue = 8'h00;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // write address and data may arrive in either order
    if (awvalid && st_reg.awReady) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = awaddr;
    end
    if (wvalid && st_reg.wReady) begin
      st_next.wHeld  = 1'b1;
      st_next.wData  = wdata[7:0];
      st_next.wLane0 = wstrb[0];
    end
    if (st_reg.bValid && bready) begin
      st_next.bValid = 1'b0;
    end
    if (doWrite) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld  = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp  = (wrSel == comparator_ctrl_pkg::SEL_NONE) ? comparator_ctrl_pkg::RESP_SLVERR
                                                                : comparator_ctrl_pkg::RESP_OKAY;
      if (st_reg.wLane0) begin
        case (wrSel)
          comparator_ctrl_pkg::SEL_CS: begin
            st_next.on    = st_reg.wData[comparator_ctrl_pkg::CS_ON_BIT];
            st_next.hysteresis_select  = st_reg.wData[comparator_ctrl_pkg::CS_HYSTERESIS_SELECT_BIT];
            st_next.irqEn = st_reg.wData[comparator_ctrl_pkg::CS_IRQEN_BIT];
            st_next.pinEn = st_reg.wData[comparator_ctrl_pkg::CS_PINEN_BIT];
            st_next.mode  = st_reg.wData[1:0];
            if (!st_reg.wData[comparator_ctrl_pkg::CS_FLAG_BIT]) begin
              st_next.flag = 1'b0;
            end
          end
          comparator_ctrl_pkg::SEL_C0: begin
            // reserved bits are simply not stored
            st_next.psel = st_reg.wData[comparator_ctrl_pkg::C0_PSEL_LSB +: 2];
            st_next.nsel = st_reg.wData[comparator_ctrl_pkg::C0_NSEL_LSB +: 2];
          end
          comparator_ctrl_pkg::SEL_C1: st_next.dac   = st_reg.wData;
          comparator_ctrl_pkg::SEL_C2: st_next.pinIn = st_reg.wData[comparator_ctrl_pkg::C2_PIN_W-1:0];
          default: ;
        endcase
      end
    end
    // a set in the clearing cycle wins, no edge is lost
    if (path.qualify) begin
      st_next.flag = 1'b1;
    end
    if (st_reg.rValid && rready) begin
      st_next.rValid = 1'b0;
    end
    if (arvalid && st_reg.arReady) begin
      st_next.rValid = 1'b1;
      st_next.rData  = {24'h00_0000, rdValue};
      st_next.rResp  = (rdSel == comparator_ctrl_pkg::SEL_NONE) ? comparator_ctrl_pkg::RESP_SLVERR
                                                                : comparator_ctrl_pkg::RESP_OKAY;
    end
    st_next.awReady = !st_next.awHeld && !st_next.bValid;
    st_next.wReady  = !st_next.wHeld && !st_next.bValid;
    st_next.arReady = !st_next.rValid;
    st_next.irq     = st_next.flag & st_next.irqEn;
    st_next.pinOut  = path.resultNow & st_next.pinEn;
    st_next.pinOe   = st_next.pinEn;
    // always-on edge logic in the analog domain uses these in stop3
    st_next.wake    = st_next.on & st_next.irqEn;
  end

  // reset leaves everything off, DAC enable included
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready          = st_reg.awReady;
  assign wready           = st_reg.wReady;
  assign bvalid           = st_reg.bValid;
  assign bresp            = st_reg.bResp;
  assign arready          = st_reg.arReady;
  assign rvalid           = st_reg.rValid;
  assign rdata            = st_reg.rData;
  assign rresp            = st_reg.rResp;
  assign comparatorOn     = st_reg.on;
  assign hysteresisSelect = st_reg.hysteresis_select;
  // inputs are applied as stored; changing them while on is software's hazard
  assign plusInputSelect  = st_reg.psel;
  assign minusInputSelect = st_reg.nsel;
  assign dacLevelCtrl     = st_reg.dac;
  assign pinInputEnable   = st_reg.pinIn;
  assign edgeIrq          = st_reg.irq;
  assign resultPin        = st_reg.pinOut;
  assign resultPinOe      = st_reg.pinOe;
  assign wakeArm          = st_reg.wake;
  assign wakeEdgeSense    = st_reg.mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_flag_sets_next: assert property (@(posedge core_clk) disable iff (!rst_n)
    path.qualify |=> st_reg.flag)
    else $error("qualifying edge did not set the flag");
  a_flag_one_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    csWrite && st_reg.wData[5] && !st_reg.flag && !path.qualify |=> !st_reg.flag)
    else $error("writing one changed the flag");
  a_flag_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    csWrite && !st_reg.wData[5] && !path.qualify |=> !st_reg.flag)
    else $error("writing zero did not clear the flag");
  a_irq_gated_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_reg.irqEn |-> !edgeIrq)
    else $error("interrupt raised while masked");
  a_irq_follows_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    path.qualify && st_reg.irqEn && !csWrite |=> edgeIrq)
    else $error("enabled flag did not raise the interrupt");
  a_result_zero_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_reg.on |-> !path.resultNow)
    else $error("result nonzero while disabled");
  a_pin_blocked: assert property (@(posedge core_clk) disable iff (!rst_n)
    !resultPinOe |-> !resultPin)
    else $error("result reached pin while pad disabled");
  a_c0_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
    arvalid && arready && (rdSel == comparator_ctrl_pkg::SEL_C0) |=> rdata[7:6] == 2'b00 && rdata[3:2] == 2'b00)
    else $error("reserved input select bits read nonzero");
  a_bresp_after_both: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(bvalid) |-> $past(st_reg.awHeld) && $past(st_reg.wHeld))
    else $error("write answered before address and data");

  // ----------------------------------------------------------------
  // field, flag and handshake checks
  // ----------------------------------------------------------------
  a_on_follows_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    csWrite |=> comparatorOn == $past(st_reg.wData[comparator_ctrl_pkg::CS_ON_BIT]))
    else $error("enable bit not taken from write");
  a_hysteresis_select_follows_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    csWrite |=> hysteresisSelect == $past(st_reg.wData[comparator_ctrl_pkg::CS_HYSTERESIS_SELECT_BIT]))
    else $error("hysteresis bit not taken from write");
  a_flag_needs_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st_reg.flag) |-> $past(path.qualify))
    else $error("flag set without qualifying edge");
  a_edge_from_raw: assert property (@(posedge core_clk) disable iff (!rst_n)
    path.qualify |-> $past(rawCompareOutput, 2) != $past(rawCompareOutput, 3))
    else $error("edge not backed by raw change");
  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.flag && !csWrite |=> st_reg.flag)
    else $error("flag dropped without clearing write");
  a_irq_when_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.flag && st_reg.irqEn |-> edgeIrq)
    else $error("enabled flag without interrupt");
  a_pin_follows_result: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.pinEn |-> resultPin == $past(path.resultNow))
    else $error("pin does not follow result");
  a_c0_write_fields: assert property (@(posedge core_clk) disable iff (!rst_n)
    doWrite && st_reg.wLane0 && (wrSel == comparator_ctrl_pkg::SEL_C0) |=>
      plusInputSelect == $past(st_reg.wData[5:4]) && minusInputSelect == $past(st_reg.wData[1:0]))
    else $error("input select not taken from write");
  a_wake_armed: assert property (@(posedge core_clk) disable iff (!rst_n)
    wakeArm == (st_reg.on & st_reg.irqEn))
    else $error("wake arm wrong");
  a_wake_sense_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    wakeEdgeSense == st_reg.mode)
    else $error("wake edge sense wrong");
  a_off_no_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st_reg.on |=> !$rose(st_reg.flag))
    else $error("flag set while disabled");
  a_write_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    rvalid |-> !arready)
    else $error("read accepted while data pending");
  a_rdata_high_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read data nonzero");
  a_unmapped_slverr: assert property (@(posedge core_clk) disable iff (!rst_n)
    arvalid && arready && (rdSel == comparator_ctrl_pkg::SEL_NONE) |=>
      rresp == comparator_ctrl_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  c_flag_set:    cover property (@(posedge core_clk) disable iff (!rst_n) $rose(st_reg.flag));
  c_flag_clear:  cover property (@(posedge core_clk) disable iff (!rst_n) $fell(st_reg.flag));
  c_set_wins:    cover property (@(posedge core_clk) disable iff (!rst_n) csWrite && path.qualify);
  c_irq_raised:  cover property (@(posedge core_clk) disable iff (!rst_n) $rose(edgeIrq));
  c_fall_taken:  cover property (@(posedge core_clk) disable iff (!rst_n) path.fallSeen && path.qualify);
endmodule : comparator_ctrl_regs

//--- core/edge_qualify.sv
// picks which result edges count under the edge sense setting
`timescale 1ns/10ps
module edge_qualify (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  result_path_if.qual   path
);
  always_comb begin
    case (path.edgeSenseSelect)
      comparator_ctrl_pkg::MODE_RISE: path.qualify = path.riseSeen;
      comparator_ctrl_pkg::MODE_BOTH: path.qualify = path.riseSeen | path.fallSeen;
      default:                        path.qualify = path.fallSeen;
    endcase
  end

  a_mode_rise_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (path.edgeSenseSelect == comparator_ctrl_pkg::MODE_RISE) && path.fallSeen && !path.riseSeen |-> !path.qualify)
    else $error("falling edge qualified in rising mode");
  a_mode_fall_both: assert property (@(posedge core_clk) disable iff (!rst_n)
    (path.edgeSenseSelect != comparator_ctrl_pkg::MODE_RISE) && path.fallSeen |-> path.qualify)
    else $error("falling edge not qualified");
endmodule : edge_qualify

//--- core/result_path_if.sv
// carrier between control, synchroniser and edge qualifier
`timescale 1ns/10ps
interface result_path_if;
  logic       compOn;
  logic [1:0] edgeSenseSelect;
  logic       resultNow;
  logic       riseSeen;
  logic       fallSeen;
  logic       qualify;

  modport ctrl (output compOn, output edgeSenseSelect, input resultNow, input qualify);
  modport sync (input compOn, output resultNow, output riseSeen, output fallSeen);
  modport qual (input edgeSenseSelect, input riseSeen, input fallSeen, output qualify);
endinterface : result_path_if

//--- core/result_sync.sv
// synchroniser and edge detector for the raw comparator output
`timescale 1ns/10ps
module result_sync (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire logic     rawCompareOutput,
  result_path_if.sync   path
);
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
    logic onPrev;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // stage1 feeds stage2 only; flag therefore lags the raw output
  always_comb begin
    st_next        = st_reg;
    st_next.stage1 = rawCompareOutput;
    st_next.stage2 = st_reg.stage1;
    st_next.prev   = path.compOn & st_reg.stage2;
    st_next.onPrev = path.compOn;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign path.resultNow = path.compOn & st_reg.stage2;
  // no edge in the first cycle after enabling, avoids a false event
  assign path.riseSeen  = path.compOn & st_reg.onPrev & st_reg.stage2 & ~st_reg.prev;
  assign path.fallSeen  = path.compOn & st_reg.onPrev & ~st_reg.stage2 & st_reg.prev;

  a_sync_lag_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    path.riseSeen |-> $past(rawCompareOutput, 2) && !$past(rawCompareOutput, 3))
    else $error("rise seen without raw rise two cycles back");
  a_no_edge_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(path.compOn) |-> !path.riseSeen && !path.fallSeen)
    else $error("edge reported right after enable");
endmodule : result_sync

//--- tb/analog_core_model.sv
// behavioural analog comparator core feeding the raw output
`timescale 1ns/10ps
module analog_core_model (
  input  wire logic compOn,
  input  wire logic inputAbove,
  output logic      rawOut
);
  // ----------------------------------------------------------------
  // comparison
  // ----------------------------------------------------------------
  // no analog delay modelled; a parked core gives a steady low
  assign rawOut = compOn & inputAbove;
endmodule : analog_core_model

//--- tb/comparator_control_regs_test.sv
// self-checking bench for the comparator control registers
`timescale 1ns/10ps
module comparator_control_regs_test;
  logic core_clk, rst_n, inputAbove, rawCompareOutput;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, plusInputSelect, minusInputSelect, wakeEdgeSense;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic comparatorOn, hysteresisSelect, edgeIrq, resultPin, resultPinOe, wakeArm;
  logic [7:0] dacLevelCtrl;
  logic [2:0] pinInputEnable;
  int num_errors = 0;
  int n_tests = 0;
  logic [7:0] cs;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  analog_core_model analog_core_model_inst (.compOn(comparatorOn), .inputAbove(inputAbove),
    .rawOut(rawCompareOutput));
  comparator_ctrl_regs comparator_ctrl_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awprot(3'b000), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'b000), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rawCompareOutput(rawCompareOutput),
    .comparatorOn(comparatorOn), .hysteresisSelect(hysteresisSelect),
    .plusInputSelect(plusInputSelect), .minusInputSelect(minusInputSelect),
    .dacLevelCtrl(dacLevelCtrl), .pinInputEnable(pinInputEnable), .edgeIrq(edgeIrq),
    .resultPin(resultPin), .resultPinOe(resultPinOe), .wakeArm(wakeArm), .wakeEdgeSense(wakeEdgeSense));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // ready seen at the falling edge is what the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge core_clk);
    awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(negedge core_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      if (bvalid === 1'b1) begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge core_clk);
        bready <= 1'b0;
        return;
      end
      @(posedge core_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    num_errors++;
    wrap_up();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(negedge core_clk);
      ar = arvalid & arready;
      if (rvalid === 1'b1) begin
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge core_clk);
        rready <= 1'b0;
        return;
      end
      @(posedge core_clk);
      if (ar) arvalid <= 1'b0;
    end
    num_errors++;
    wrap_up();
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : ticks
  // ----------------------------------------------------------------
  // clock, reset, sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0; inputAbove = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
    wstrb = 4'hf; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'hb0 + 8'(4 * i), 32'h0000_0000, 2'b00);
    chk("comparatorOn", 32'h0, {31'h0, comparatorOn});
    for (int i = 0; i < 4; i++) begin
      wr(8'hb4, 8'hcc | 8'(i * 17), 2'b00);
      rd(8'hb4, 32'(i * 17), 2'b00);
      chk("plusInputSelect", 32'(i), {30'h0, plusInputSelect});
      chk("minusInputSelect", 32'(i), {30'h0, minusInputSelect});
    end
    wr(8'hb8, 8'ha5, 2'b00);
    rd(8'hb8, 32'h0000_00a5, 2'b00);
    chk("dacLevelCtrl", 32'h0000_00a5, {24'h0, dacLevelCtrl});
    wstrb <= 4'he;
    wr(8'hb8, 8'h5a, 2'b00);
    wstrb <= 4'hf;
    chk("dacLevelCtrl lane", 32'h0000_00a5, {24'h0, dacLevelCtrl});
    wr(8'hbc, 8'hff, 2'b00);
    rd(8'hbc, 32'h0000_0007, 2'b00);
    chk("pinInputEnable", 32'h0000_0007, {29'h0, pinInputEnable});
    wr(8'hc0, 8'hff, 2'b10);
    rd(8'hc0, 32'h0000_0000, 2'b10);
    wr(8'hb0, 8'h40, 2'b00);
    chk("hysteresisSelect", 32'h1, {31'h0, hysteresisSelect});
    chk("comparatorOn", 32'h0, {31'h0, comparatorOn});
    for (int m = 0; m < 4; m++) begin
      cs = 8'h94 | 8'(m);
      wr(8'hb0, cs, 2'b00);
      chk("wakeArm", 32'h1, {31'h0, wakeArm});
      chk("wakeEdgeSense", 32'(m), {30'h0, wakeEdgeSense});
      inputAbove <= 1'b1;
      @(negedge core_clk);
      chk("edgeIrq early", 32'h0, {31'h0, edgeIrq});
      ticks(4);
      @(negedge core_clk);
      chk("edgeIrq rise", 32'((m % 2) == 1), {31'h0, edgeIrq});
      chk("resultPin", 32'h1, {31'h0, resultPin});
      chk("resultPinOe on", 32'h1, {31'h0, resultPinOe});
      rd(8'hb0, 32'(cs | 8'h08 | ((m % 2) == 1 ? 8'h20 : 8'h00)), 2'b00);
      wr(8'hb0, cs | 8'h20, 2'b00);
      rd(8'hb0, 32'(cs | 8'h08 | ((m % 2) == 1 ? 8'h20 : 8'h00)), 2'b00);
      wr(8'hb0, cs, 2'b00);
      inputAbove <= 1'b0;
      ticks(5);
      rd(8'hb0, 32'(cs | (m != 1 ? 8'h20 : 8'h00)), 2'b00);
      wr(8'hb0, cs, 2'b00);
      rd(8'hb0, 32'(cs), 2'b00);
    end
    wr(8'hb0, 8'h83, 2'b00);
    inputAbove <= 1'b1;
    ticks(5);
    @(negedge core_clk);
    chk("edgeIrq masked", 32'h0, {31'h0, edgeIrq});
    chk("resultPinOe", 32'h0, {31'h0, resultPinOe});
    chk("resultPin off", 32'h0, {31'h0, resultPin});
    chk("wakeArm off", 32'h0, {31'h0, wakeArm});
    rd(8'hb0, 32'h0000_00ab, 2'b00);
    wr(8'hb0, 8'h03, 2'b00);
    ticks(4);
    rd(8'hb0, 32'h0000_0003, 2'b00);
    chk("comparatorOn", 32'h0, {31'h0, comparatorOn});
    wrap_up();
  end
endmodule : comparator_control_regs_test
